// ### rtl/vtr_ctrl.sv
// How it works
// - select zero: vectors at flash start
// - select one: vectors at boot start
// - 2K boot: vectors start word 0xC00
// - select changes only within unlock window
// - mask interrupts from unlock until after write
// - no select write: mask four cycles
// - global interrupt flag never touched here
// - boot vectors, app lock: block in app
// - app vectors, boot lock: block in boot
// - unlock self-clears after four cycles, or write
// - pull-up disable drives all ports off
`timescale 1ns/1ps
`default_nettype none
module vtr_ctrl
  import vtr_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input wire logic [1:0] boot_size_fuses_i,
  input wire logic app_side_boot_lock_i,
  input wire logic boot_side_boot_lock_i,
  input wire logic exec_in_boot_i,
  input wire logic [4:0] vector_index_i,
  output logic [11:0] vector_addr_o,
  output logic irq_block_o,
  output logic global_pullup_disable_o,
  output logic serial_pin_alt_select_o,
  output logic vector_base_select_o
);
  import vtr_pkg::*;

  vtr_unlock_if uif ();

  vtr_unlock_timer u_timer (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .u(uif.timer)
  );

  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic hold_q;
  logic hold_d;
  logic unlock_wr;
  logic sel_wr;

  // boot section start for the fuse setting
  function automatic logic [11:0] boot_base(input logic [1:0] sz);
    unique case (sz)
      2'b00: boot_base = BOOT_BASE_0;
      2'b01: boot_base = BOOT_BASE_1;
      2'b10: boot_base = BOOT_BASE_2;
      2'b11: boot_base = BOOT_BASE_3;
    endcase
  endfunction

  // write decode of the control register
  assign unlock_wr = reg_wr_i & reg_wdata_i[BIT_UNLOCK];
  assign sel_wr = reg_wr_i & ~reg_wdata_i[BIT_UNLOCK] & uif.open;
  assign uif.arm = unlock_wr;
  assign uif.cancel = sel_wr;

  // next register value
  always_comb
  begin
    ctrl_d = ctrl_q;
    if (reg_wr_i)
    begin
      ctrl_d[BIT_ALT_SERIAL] = reg_wdata_i[BIT_ALT_SERIAL];
      ctrl_d[BIT_PULLUP_DIS] = reg_wdata_i[BIT_PULLUP_DIS];
    end
    if (sel_wr)
      ctrl_d[BIT_VEC_SEL] = reg_wdata_i[BIT_VEC_SEL];
    // unlock state lives in the timer, the stored bit stays clear
    ctrl_d[BIT_UNLOCK] = 1'b0;
    ctrl_d = ctrl_d & CTRL_WMASK;
    // one-cycle mask extension covers the instruction after the write
    hold_d = sel_wr;
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ctrl_q <= CTRL_RESET;
      hold_q <= 1'b0;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      hold_q <= hold_d;
    end
  end

  // readback: unlock bit mirrors the live window
  always_comb
  begin
    reg_rdata_o = ctrl_q;
    reg_rdata_o[BIT_UNLOCK] = uif.open;
  end

  // vector placement
  always_comb
  begin
    if (ctrl_q[BIT_VEC_SEL])
      vector_addr_o = boot_base(boot_size_fuses_i) + {7'h00, vector_index_i};
    else
      vector_addr_o = APP_BASE + {7'h00, vector_index_i};
  end

  // interrupt blocking, separate from the cpu enable flag
  assign irq_block_o = uif.open | hold_q
    | (ctrl_q[BIT_VEC_SEL] & app_side_boot_lock_i & ~exec_in_boot_i)
    | (~ctrl_q[BIT_VEC_SEL] & boot_side_boot_lock_i & exec_in_boot_i);

  assign global_pullup_disable_o = ctrl_q[BIT_PULLUP_DIS];
  assign serial_pin_alt_select_o = ctrl_q[BIT_ALT_SERIAL];
  assign vector_base_select_o = ctrl_q[BIT_VEC_SEL];
endmodule
`default_nettype wire

// ### rtl/vtr_pkg.sv
package vtr_pkg;
  // control register layout
  localparam int unsigned CTRL_W = 8;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int unsigned BIT_ALT_SERIAL = 7;
  localparam int unsigned BIT_PULLUP_DIS = 4;
  localparam int unsigned BIT_VEC_SEL = 1;
  localparam int unsigned BIT_UNLOCK = 0;
  localparam logic [7:0] CTRL_WMASK = 8'h93;
  // unlock window length in cycles
  localparam int unsigned UNLOCK_CYCLES = 4;
  localparam logic [2:0] UNLOCK_CNT_LOAD = 3'(UNLOCK_CYCLES);
  // word addresses
  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] APP_BASE = 12'h000;
  // boot start per boot size fuse code (code 2'b00 is 2K bytes)
  localparam logic [11:0] BOOT_BASE_0 = 12'h0C00;
  localparam logic [11:0] BOOT_BASE_1 = 12'h0E00;
  localparam logic [11:0] BOOT_BASE_2 = 12'h0F00;
  localparam logic [11:0] BOOT_BASE_3 = 12'h0F80;
endpackage

// ### rtl/vtr_unlock_if.sv
`timescale 1ns/1ps
`default_nettype none
// unlock timer signals between top and timer
interface vtr_unlock_if;
  logic arm;
  logic cancel;
  logic open;
  modport ctrl (output arm, output cancel, input open);
  modport timer (input arm, input cancel, output open);
endinterface
`default_nettype wire

// ### rtl/vtr_unlock_timer.sv
`timescale 1ns/1ps
`default_nettype none
module vtr_unlock_timer
  import vtr_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  vtr_unlock_if.timer u
);
  logic [2:0] cnt_q;
  logic [2:0] cnt_d;

  // countdown of the unlock window
  always_comb
  begin
    cnt_d = cnt_q;
    if (u.arm)
      cnt_d = UNLOCK_CNT_LOAD;
    else if (u.cancel)
      cnt_d = 3'h0;
    else if (cnt_q != 3'h0)
      cnt_d = cnt_q - 3'h1;
  end

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
      cnt_q <= 3'h0;
    else
      cnt_q <= cnt_d;
  end

  assign u.open = (cnt_q != 3'h0);
endmodule
`default_nettype wire

// ### sim/vtr_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module vtr_cpu_model (
  input wire logic mclk_i,
  output logic reg_wr_o,
  output logic [7:0] reg_wdata_o
);
  // one-cycle store, idle data inverted so nothing stale shows
  task automatic wr(input logic [7:0] d);
    @(negedge mclk_i);
    reg_wr_o = 1'b1;
    reg_wdata_o = d;
    @(negedge mclk_i);
    reg_wr_o = 1'b0;
    reg_wdata_o = ~d;
  endtask
  initial
  begin
    reg_wr_o = 1'b0;
    reg_wdata_o = 8'h00;
  end
endmodule
`default_nettype wire

// ### sim/vtr_ctrl_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module vtr_ctrl_monitor
  import vtr_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [1:0] boot_size_fuses_i,
  input wire logic app_side_boot_lock_i,
  input wire logic boot_side_boot_lock_i,
  input wire logic exec_in_boot_i,
  input wire logic [4:0] vector_index_i,
  input wire logic [11:0] vector_addr_o,
  input wire logic irq_block_o,
  input wire logic global_pullup_disable_o,
  input wire logic vector_base_select_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  // short names for the select level and an unlock write
  wire logic sel = vector_base_select_o;
  wire logic arm = reg_wr_i && reg_wdata_i[0];
  a_app_base: assert property (!sel |-> vector_addr_o == 12'(vector_index_i))
    else $error("app base");
  a_boot_base: assert property (sel && boot_size_fuses_i == 2'b00 |->
    vector_addr_o == BOOT_BASE_0 + 12'(vector_index_i)) else $error("boot base");
  a_sel_guard: assert property (!(reg_wr_i && reg_rdata_o[0] && !reg_wdata_i[0]) |=>
    $stable(sel)) else $error("sel guard");
  a_unlock_open: assert property (arm |=> reg_rdata_o[0] && irq_block_o)
    else $error("unlock open");
  a_unlock_end: assert property (arm ##1 !reg_wr_i [*4] |=> !reg_rdata_o[0])
    else $error("unlock end");
  a_write_close: assert property (reg_wr_i && !reg_wdata_i[0] |=> !reg_rdata_o[0])
    else $error("write close");
  a_lock_block: assert property ((sel ? app_side_boot_lock_i && !exec_in_boot_i :
    boot_side_boot_lock_i && exec_in_boot_i) |-> irq_block_o) else $error("lock");
  a_pullup_out: assert property (reg_wr_i |=>
    global_pullup_disable_o == $past(reg_wdata_i[4])) else $error("pullup");
endmodule
bind vtr_ctrl vtr_ctrl_monitor i_mon (.*);
`default_nettype wire

// ### sim/vtr_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module vtr_ctrl_tb;
  import vtr_pkg::*;
  logic mclk_i, rst_i, reg_wr_i, app_side_boot_lock_i, boot_side_boot_lock_i, exec_in_boot_i;
  logic irq_block_o, global_pullup_disable_o, serial_pin_alt_select_o, vector_base_select_o;
  logic [7:0] reg_wdata_i, reg_rdata_o;
  logic [1:0] boot_size_fuses_i;
  logic [4:0] vector_index_i;
  logic [11:0] vector_addr_o;
  logic [19:0] q[$];
  logic [19:0] note;
  int error_cnt, n_checks;
  vtr_cpu_model i_cpu (.mclk_i, .reg_wr_o(reg_wr_i), .reg_wdata_o(reg_wdata_i));
  vtr_ctrl i_dut (.*);
  task automatic chk(input logic [19:0] s, input logic [19:0] e);
    n_checks++;
    if (s !== e)
    begin
      error_cnt++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // random index and locks, then a write with its expected readback noted
  task automatic step(input logic [7:0] d, input logic [7:0] e);
    @(negedge mclk_i);
    {vector_index_i, app_side_boot_lock_i, boot_side_boot_lock_i, exec_in_boot_i} = 8'($urandom);
    q.push_back({e[1] ? BOOT_BASE_0 + 12'(vector_index_i) : 12'(vector_index_i), e});
    i_cpu.wr(d);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end
  // result watcher: one note per write, refused select writes included
  always @(posedge mclk_i)
    if (reg_wr_i === 1'b1 && q.size() > 0)
    begin
      @(negedge mclk_i);
      note = q.pop_front();
      chk({vector_addr_o, reg_rdata_o}, note);
      chk(20'({serial_pin_alt_select_o, global_pullup_disable_o, vector_base_select_o}),
        20'({note[7], note[4], note[1]}));
    end
  initial
  begin
    #5000;
    error_cnt++;
    end_sim;
  end
  initial
  begin
    {rst_i, boot_size_fuses_i, vector_index_i, app_side_boot_lock_i} = 9'h100;
    {boot_side_boot_lock_i, exec_in_boot_i} = 2'b00;
    void'($urandom(95532));
    repeat (6) @(posedge mclk_i);
    @(negedge mclk_i);
    rst_i = 1'b0;
    chk({vector_addr_o, reg_rdata_o}, 20'h0_0000);
    step(8'hEE, 8'h80);
    $display("refused select done");
    step(8'h01, 8'h01);
    step(8'h12, 8'h12);
    $display("select move done");
    step(8'h01, 8'h03);
    repeat (5) @(negedge mclk_i);
    step(8'h10, 8'h12);
    step(8'h01, 8'h03);
    step(8'h00, 8'h00);
    $display("window expiry done");
    repeat (3) @(negedge mclk_i);
    end_sim;
  end
endmodule
`default_nettype wire
